// file: core/lockin_output_scaling.sv
// output scaling datapath: sensitivity, offset, ratio, expand, limiting
// assumes measurements and aux codes from logic on mclk, Avalon-MM master
//
// Overview of operation
// - rear X, Y and both front channels refresh at 2.222 MHz
// - front one carries X or R, front two carries Y or phase
// - front channel set to X or Y equals the rear output exactly
// - sensitivity sets the input level giving ten volts full scale
// - X and Y are signed, spanning minus to plus ten volts
// - above sensitivity flag overload, saturate outputs, keep raw result
// - phase spans plus/minus 180 degrees, independent of sensitivity
// - phase output scale is 18 degrees per volt
// - offsets are held as percent of sensitivity, up to 999 percent
// - output is (value/sens minus offset)/(ratio/1 V) times expand times 10 V
// - expand is 1, 10 or 100; output magnitude at most ten volts
// - ratio divisor is aux three for X, Y, aux four for R, else one
// - ratio enabled lights the ratio lamp and display labels
// - X/Y and R have separate offset, ratio, expand; phase has none
// - bars, readouts and charts include offsets and ratios
// - remote query values include offset and ratio
// - non-zero offset raises that display's offset indicator
// - non-unity ratio raises that display's ratio indicator
// - readouts ignore expand; non-unity expand raises expand indicator
// - bar values follow the expanded connector values
// - chart values ignore expand but include offsets
// - phase bar and readout do not depend on sensitivity
// - overload only above 100 percent, pinning connector and bar; readout clamps at its own unexpanded limit
module lockin_output_scaling #(
	parameter int RATE_HZ = lockin_scale_pkg::RATE_HZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic meas_valid,
	input wire lockin_scale_pkg::meas_t meas,
	input wire logic signed [lockin_scale_pkg::AUX_W-1:0] aux_three,
	input wire logic signed [lockin_scale_pkg::AUX_W-1:0] aux_four,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output lockin_scale_pkg::conn_t conn,
	output lockin_scale_pkg::conn_t bar,
	output lockin_scale_pkg::readout_t readout,
	output lockin_scale_pkg::chart_t chart,
	output lockin_scale_pkg::ind_t ind,
	output logic update
);
	localparam int MW = lockin_scale_pkg::MW;
	localparam int OW = lockin_scale_pkg::OUT_W;
	localparam int AW = lockin_scale_pkg::ACC_W;
	localparam logic [AW-1:0] INC = AW'((64'(RATE_HZ) << AW) / 64'(lockin_scale_pkg::CLK_HZ));
	localparam logic signed [MW-1:0] K_OFF = MW'(lockin_scale_pkg::OFF_UNITS);
	localparam logic signed [MW-1:0] K_FS = MW'(lockin_scale_pkg::FS_CODE);
	localparam logic signed [MW-1:0] K_AUX = MW'(lockin_scale_pkg::AUX_ONE);
	localparam logic signed [MW-1:0] K_RES = MW'(lockin_scale_pkg::READ_RES);
	localparam logic signed [MW-1:0] K_RD = K_FS * K_RES;
	localparam logic signed [MW-1:0] K_TH = MW'(lockin_scale_pkg::THETA_HALF);
	localparam logic signed [OW-1:0] FS_P = OW'(lockin_scale_pkg::FS_CODE);

	// rate divider and sequencer
	logic [AW-1:0] acc;
	logic tick;
	lockin_scale_pkg::seq_t state;
	lockin_scale_pkg::meas_t latest;
	lockin_scale_pkg::meas_t snap;

	// registers
	logic [7:0] ctrl;
	logic [31:0] sens;
	logic signed [lockin_scale_pkg::OFF_W-1:0] off_x;
	logic signed [lockin_scale_pkg::OFF_W-1:0] off_y;
	logic signed [lockin_scale_pkg::OFF_W-1:0] off_r;
	logic rd_done;

	// datapath
	logic signed [lockin_scale_pkg::VAL_W-1:0] v_sel;
	logic signed [lockin_scale_pkg::OFF_W-1:0] off_sel;
	logic signed [MW-1:0] aux_eff;
	logic signed [MW-1:0] exp_mul;
	logic signed [MW-1:0] base;
	logic signed [MW-1:0] den;
	logic signed [MW-1:0] q_out;
	logic signed [MW-1:0] q_rd;
	logic signed [OW-1:0] code;
	logic signed [lockin_scale_pkg::RD_W-1:0] rd_code;
	logic signed [lockin_scale_pkg::CH_W-1:0] ch_code;
	logic ovl;
	logic [OW-1:0] res_x;
	logic [OW-1:0] res_y;
	logic [lockin_scale_pkg::RD_W-1:0] rd_x;
	logic [lockin_scale_pkg::RD_W-1:0] rd_y;
	logic [lockin_scale_pkg::CH_W-1:0] cx;
	logic [lockin_scale_pkg::CH_W-1:0] cy;
	logic [1:0] ovl_xy;
	logic signed [OW-1:0] th_code;
	logic signed [MW-1:0] th_q;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic signed [lockin_scale_pkg::OFF_W-1:0] off_new;

	function automatic logic signed [MW-1:0] exp_factor(input logic [1:0] sel);
		case (sel)
			lockin_scale_pkg::EXP_10: exp_factor = MW'(10);
			lockin_scale_pkg::EXP_100: exp_factor = MW'(100);
			default: exp_factor = MW'(1);
		endcase
	endfunction : exp_factor

	// phase accumulator: carry out is the sample strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc <= '0;
			tick <= 1'b0;
		end else begin
			{tick, acc} <= {1'b0, acc} + {1'b0, INC};
		end
	end

	// newest filtered result, floating value kept untouched
	always_ff @(posedge mclk) begin
		if (rst) begin
			latest <= '0;
		end else if (meas_valid) begin
			latest <= meas;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= lockin_scale_pkg::ST_IDLE;
			snap <= '0;
		end else begin
			case (state)
				lockin_scale_pkg::ST_IDLE: begin
					if (tick) begin
						snap <= latest;
						state <= lockin_scale_pkg::ST_X;
					end
				end
				lockin_scale_pkg::ST_X: state <= lockin_scale_pkg::ST_Y;
				lockin_scale_pkg::ST_Y: state <= lockin_scale_pkg::ST_R;
				lockin_scale_pkg::ST_R: state <= lockin_scale_pkg::ST_IDLE;
				default: state <= lockin_scale_pkg::ST_IDLE;
			endcase
		end
	end

	// per-step operand selection
	always_comb begin
		v_sel = snap.x;
		off_sel = off_x;
		aux_eff = K_AUX;
		exp_mul = exp_factor(ctrl[lockin_scale_pkg::CTRL_EXP_XY +: 2]);
		case (state)
			lockin_scale_pkg::ST_Y: begin
				v_sel = snap.y;
				off_sel = off_y;
			end
			lockin_scale_pkg::ST_R: begin
				v_sel = snap.r;
				off_sel = off_r;
				exp_mul = exp_factor(ctrl[lockin_scale_pkg::CTRL_EXP_R +: 2]);
			end
			default: begin
				v_sel = snap.x;
			end
		endcase
		if (state == lockin_scale_pkg::ST_R) begin
			if (ctrl[lockin_scale_pkg::CTRL_RAT_R]) begin
				aux_eff = MW'(aux_four);
			end
		end else if (ctrl[lockin_scale_pkg::CTRL_RAT_XY]) begin
			aux_eff = MW'(aux_three);
		end
	end

	// value*10000 - offset*sens, over sens*10000*aux/1V
	always_comb begin
		base = MW'(v_sel) * K_OFF - MW'(off_sel) * $signed({64'h0, sens});
		den = $signed({64'h0, sens}) * K_OFF * aux_eff;
		q_out = '0;
		q_rd = '0;
		if (den != '0) begin
			q_out = (base * exp_mul * K_FS * K_AUX) / den;
			q_rd = (base * K_RES * K_FS * K_AUX) / den;
		end
	end

	// limiting and conversion to codes
	always_comb begin
		ovl = 1'b0;
		code = q_out[OW-1:0];
		rd_code = q_rd[lockin_scale_pkg::RD_W-1:0];
		ch_code = q_rd[lockin_scale_pkg::CH_W-1:0];
		if (den == '0) begin
			ovl = 1'b1;
			code = base[MW-1] ? -FS_P : FS_P;
			rd_code = base[MW-1] ? -K_RD[lockin_scale_pkg::RD_W-1:0] : K_RD[lockin_scale_pkg::RD_W-1:0];
			ch_code = '0;
		end else if (q_out > K_FS) begin
			ovl = 1'b1;
			code = FS_P;
		end else if (q_out < -K_FS) begin
			ovl = 1'b1;
			code = -FS_P;
		end
		if (den != '0) begin
			if (q_rd > K_RD) begin
				rd_code = K_RD[lockin_scale_pkg::RD_W-1:0];
			end else if (q_rd < -K_RD) begin
				rd_code = -K_RD[lockin_scale_pkg::RD_W-1:0];
			end
		end
	end

	// phase scale, 180 deg maps to full scale, no sensitivity term
	always_comb begin
		th_q = (MW'(snap.theta) * K_FS) / K_TH;
		th_code = th_q[OW-1:0];
		if (th_q > K_FS) begin
			th_code = FS_P;
		end else if (th_q < -K_FS) begin
			th_code = -FS_P;
		end
	end

	// staging of x and y until r is done
	always_ff @(posedge mclk) begin
		if (rst) begin
			res_x <= '0;
			res_y <= '0;
			rd_x <= '0;
			rd_y <= '0;
			cx <= '0;
			cy <= '0;
			ovl_xy <= '0;
		end else if (state == lockin_scale_pkg::ST_X) begin
			res_x <= code;
			rd_x <= rd_code;
			cx <= ch_code;
			ovl_xy[0] <= ovl;
		end else if (state == lockin_scale_pkg::ST_Y) begin
			res_y <= code;
			rd_y <= rd_code;
			cy <= ch_code;
			ovl_xy[1] <= ovl;
		end
	end

	// publish connector, bar, readout, chart and overload flags together once per sample
	always_ff @(posedge mclk) begin
		if (rst) begin
			conn <= '0;
			bar <= '0;
			readout <= '0;
			chart <= '0;
			ind.overload <= '0;
			update <= 1'b0;
		end else begin
			update <= 1'b0;
			if (state == lockin_scale_pkg::ST_R) begin
				conn.x <= res_x;
				conn.y <= res_y;
				conn.r <= code;
				conn.theta <= th_code;
				conn.ch1 <= ctrl[lockin_scale_pkg::CTRL_CH1_R] ? code : res_x;
				conn.ch2 <= ctrl[lockin_scale_pkg::CTRL_CH2_TH] ? th_code : res_y;
				bar.x <= res_x;
				bar.y <= res_y;
				bar.r <= code;
				bar.theta <= th_code;
				bar.ch1 <= ctrl[lockin_scale_pkg::CTRL_CH1_R] ? code : res_x;
				bar.ch2 <= ctrl[lockin_scale_pkg::CTRL_CH2_TH] ? th_code : res_y;
				readout.x <= rd_x;
				readout.y <= rd_y;
				readout.r <= rd_code;
				readout.theta <= snap.theta;
				chart.x <= cx;
				chart.y <= cy;
				chart.r <= ch_code;
				ind.overload <= {ovl, ovl_xy};
				update <= 1'b1;
			end
		end
	end

	// display indicators follow the settings
	always_ff @(posedge mclk) begin
		if (rst) begin
			ind.ratio_lamp <= 1'b0;
			ind.offset_ind <= '0;
			ind.ratio_ind <= '0;
			ind.expand_ind <= '0;
		end else begin
			ind.ratio_lamp <= ctrl[lockin_scale_pkg::CTRL_RAT_XY] | ctrl[lockin_scale_pkg::CTRL_RAT_R];
			ind.offset_ind <= {off_r != '0, off_y != '0, off_x != '0};
			ind.ratio_ind[0] <= ctrl[lockin_scale_pkg::CTRL_RAT_XY] && MW'(aux_three) != K_AUX;
			ind.ratio_ind[1] <= ctrl[lockin_scale_pkg::CTRL_RAT_XY] && MW'(aux_three) != K_AUX;
			ind.ratio_ind[2] <= ctrl[lockin_scale_pkg::CTRL_RAT_R] && MW'(aux_four) != K_AUX;
			ind.expand_ind[0] <= ctrl[lockin_scale_pkg::CTRL_EXP_XY +: 2] != lockin_scale_pkg::EXP_1;
			ind.expand_ind[1] <= ctrl[lockin_scale_pkg::CTRL_EXP_XY +: 2] != lockin_scale_pkg::EXP_1;
			ind.expand_ind[2] <= ctrl[lockin_scale_pkg::CTRL_EXP_R +: 2] != lockin_scale_pkg::EXP_1;
		end
	end

	// byte-lane merge of write data
	always_comb begin
		wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wval = '0;
		case (avs_address)
			lockin_scale_pkg::ADDR_CTRL: wval = {24'h0, ctrl};
			lockin_scale_pkg::ADDR_SENS: wval = sens;
			lockin_scale_pkg::ADDR_OFF_X: wval = 32'(off_x);
			lockin_scale_pkg::ADDR_OFF_Y: wval = 32'(off_y);
			lockin_scale_pkg::ADDR_OFF_R: wval = 32'(off_r);
			default: wval = '0;
		endcase
		wval = (wval & ~wmask) | (avs_writedata & wmask);
		// offsets clamp to +/-999 %
		if ($signed(wval) > lockin_scale_pkg::OFF_MAX) begin
			off_new = lockin_scale_pkg::OFF_W'(lockin_scale_pkg::OFF_MAX);
		end else if ($signed(wval) < -lockin_scale_pkg::OFF_MAX) begin
			off_new = lockin_scale_pkg::OFF_W'(-lockin_scale_pkg::OFF_MAX);
		end else begin
			off_new = wval[lockin_scale_pkg::OFF_W-1:0];
		end
	end

	// register writes, zero wait
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl <= lockin_scale_pkg::CTRL_RST;
			sens <= lockin_scale_pkg::SENS_RST;
			off_x <= lockin_scale_pkg::OFF_RST;
			off_y <= lockin_scale_pkg::OFF_RST;
			off_r <= lockin_scale_pkg::OFF_RST;
		end else if (avs_write) begin
			case (avs_address)
				lockin_scale_pkg::ADDR_CTRL: begin
					ctrl[3:0] <= wval[3:0];
					// reserved expand code keeps the old setting
					if (wval[5:4] != 2'b11) begin
						ctrl[5:4] <= wval[5:4];
					end
					if (wval[7:6] != 2'b11) begin
						ctrl[7:6] <= wval[7:6];
					end
				end
				lockin_scale_pkg::ADDR_SENS: sens <= wval;
				lockin_scale_pkg::ADDR_OFF_X: off_x <= off_new;
				lockin_scale_pkg::ADDR_OFF_Y: off_y <= off_new;
				lockin_scale_pkg::ADDR_OFF_R: off_r <= off_new;
				default: ;
			endcase
		end
	end

	// reads take one wait cycle
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_done <= 1'b0;
			avs_readdata <= '0;
		end else begin
			rd_done <= avs_read & ~rd_done;
			if (avs_read & ~rd_done) begin
				case (avs_address)
					lockin_scale_pkg::ADDR_CTRL: avs_readdata <= {24'h0, ctrl};
					lockin_scale_pkg::ADDR_SENS: avs_readdata <= sens;
					lockin_scale_pkg::ADDR_OFF_X: avs_readdata <= 32'(off_x);
					lockin_scale_pkg::ADDR_OFF_Y: avs_readdata <= 32'(off_y);
					lockin_scale_pkg::ADDR_OFF_R: avs_readdata <= 32'(off_r);
					lockin_scale_pkg::ADDR_STATUS: avs_readdata <= {19'h0, ind};
					lockin_scale_pkg::ADDR_OUT_XY: avs_readdata <= {conn.y, conn.x};
					lockin_scale_pkg::ADDR_OUT_RT: avs_readdata <= {conn.theta, conn.r};
					default: avs_readdata <= '0;
				endcase
			end
		end
	end

	assign avs_waitrequest = avs_read & ~rd_done;
endmodule : lockin_output_scaling

// file: core/lockin_scale_pkg.sv
// constants, types and register map of the output scaling datapath
// assumes one 25 MHz clock and a synchronous active-high reset
package lockin_scale_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int RATE_HZ = 2222000;
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] RATE_INC = ACC_W'((64'(RATE_HZ) << ACC_W) / 64'(CLK_HZ));
	localparam int VAL_W = 32;
	localparam int AUX_W = 16;
	localparam int OFF_W = 18;
	localparam int OUT_W = 16;
	localparam int RD_W = 24;
	localparam int CH_W = 40;
	localparam int MW = 96;
	// full scale code, 10 V at the connector
	localparam int FS_CODE = 30000;
	// offset units: 0.01 %, so 100 % = 10000
	localparam int OFF_UNITS = 10000;
	localparam int OFF_MAX = 99900;
	// auxiliary input code of 1.000 V (mV units)
	localparam int AUX_ONE = 1000;
	// phase input in millidegrees, 180 deg
	localparam int THETA_HALF = 180000;
	// extra readout resolution, as the largest expand
	localparam int READ_RES = 100;
	localparam logic [5:0] ADDR_CTRL = 6'h00;
	localparam logic [5:0] ADDR_SENS = 6'h04;
	localparam logic [5:0] ADDR_OFF_X = 6'h08;
	localparam logic [5:0] ADDR_OFF_Y = 6'h0C;
	localparam logic [5:0] ADDR_OFF_R = 6'h10;
	localparam logic [5:0] ADDR_STATUS = 6'h14;
	localparam logic [5:0] ADDR_OUT_XY = 6'h18;
	localparam logic [5:0] ADDR_OUT_RT = 6'h1C;
	localparam int CTRL_CH1_R = 0;
	localparam int CTRL_CH2_TH = 1;
	localparam int CTRL_RAT_XY = 2;
	localparam int CTRL_RAT_R = 3;
	localparam int CTRL_EXP_XY = 4;
	localparam int CTRL_EXP_R = 6;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] SENS_RST = 32'h3B9ACA00;
	localparam logic [OFF_W-1:0] OFF_RST = 18'h00000;
	typedef enum logic [1:0] {
		EXP_1 = 2'b00,
		EXP_10 = 2'b01,
		EXP_100 = 2'b10
	} expand_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_X = 2'b01,
		ST_Y = 2'b10,
		ST_R = 2'b11
	} seq_t;
	typedef struct packed {
		logic signed [VAL_W-1:0] x;
		logic signed [VAL_W-1:0] y;
		logic signed [VAL_W-1:0] r;
		logic signed [VAL_W-1:0] theta;
	} meas_t;
	typedef struct packed {
		logic signed [OUT_W-1:0] x;
		logic signed [OUT_W-1:0] y;
		logic signed [OUT_W-1:0] r;
		logic signed [OUT_W-1:0] theta;
		logic signed [OUT_W-1:0] ch1;
		logic signed [OUT_W-1:0] ch2;
	} conn_t;
	typedef struct packed {
		logic signed [RD_W-1:0] x;
		logic signed [RD_W-1:0] y;
		logic signed [RD_W-1:0] r;
		logic signed [VAL_W-1:0] theta;
	} readout_t;
	typedef struct packed {
		logic signed [CH_W-1:0] x;
		logic signed [CH_W-1:0] y;
		logic signed [CH_W-1:0] r;
	} chart_t;
	// per quantity flags, bit 0 x, bit 1 y, bit 2 r
	typedef struct packed {
		logic ratio_lamp;
		logic [2:0] offset_ind;
		logic [2:0] ratio_ind;
		logic [2:0] expand_ind;
		logic [2:0] overload;
	} ind_t;
endpackage : lockin_scale_pkg

// file: verification/lockin_scaling_props.sv
// concurrent checks on the ports of the output scaling datapath
// assumes it is bound into lockin_output_scaling; one clock mclk, reset rst
module lockin_scaling_props #(
	parameter int RATE_HZ = lockin_scale_pkg::RATE_HZ
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire lockin_scale_pkg::conn_t conn,
	input wire lockin_scale_pkg::conn_t bar,
	input wire lockin_scale_pkg::readout_t readout,
	input wire lockin_scale_pkg::ind_t ind,
	input wire logic update
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GAP_LO = lockin_scale_pkg::CLK_HZ / RATE_HZ;
	localparam int GAP_HI = GAP_LO + 1;
	localparam int FS = lockin_scale_pkg::FS_CODE;
	logic [4:0] gap;
	logic seen;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// cycles since the last refresh pulse
	always_ff @(posedge mclk) begin
		if (rst) begin
			gap <= 5'h00;
			seen <= 1'b0;
		end else if (update) begin
			gap <= 5'h01;
			seen <= 1'b1;
		end else if (gap != 5'h1F) begin
			gap <= gap + 5'h01;
		end
	end
	a_update_spacing: assert property (update && seen |-> gap >= GAP_LO && gap <= GAP_HI)
		else $error("refresh spacing wrong");
	a_update_pulse: assert property (update |=> !update)
		else $error("refresh pulse too long");
	a_outputs_hold: assert property (!update |-> $stable(conn) && $stable(readout))
		else $error("outputs moved between refreshes");
	a_front_one: assert property (conn.ch1 == conn.x || conn.ch1 == conn.r)
		else $error("front channel one carries neither x nor r");
	a_front_two: assert property (conn.ch2 == conn.y || conn.ch2 == conn.theta)
		else $error("front channel two carries neither y nor phase");
	a_bar_mirror: assert property (bar == conn)
		else $error("bar differs from connector");
	a_out_limit: assert property (conn.x <= FS && conn.x >= -FS && conn.y <= FS && conn.y >= -FS)
		else $error("connector code beyond full scale");
	a_overload_pin: assert property (ind.overload[0] |-> conn.x == FS || conn.x == -FS)
		else $error("overload without pinned output");
	a_theta_scale: assert property (conn.theta == 16'((longint'(readout.theta) * FS) / 180000))
		else $error("phase code off scale");
	a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read answer late");
	a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
endmodule : lockin_scaling_props

// file: verification/scaling_output_sink.sv
// far side model: output converters, display sink and auxiliary sampler
// assumes the bench sets the auxiliary levels; everything on mclk
module scaling_output_sink (
	input wire logic mclk,
	input wire logic rst,
	input wire logic update,
	input wire logic signed [15:0] aux3_level,
	input wire logic signed [15:0] aux4_level,
	output logic signed [lockin_scale_pkg::AUX_W-1:0] aux_three,
	output logic signed [lockin_scale_pkg::AUX_W-1:0] aux_four,
	output int unsigned samples
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge mclk) begin
		aux_three <= aux3_level;
		aux_four <= aux4_level;
	end
	// converters take a code only on the refresh pulse
	always_ff @(posedge mclk) begin
		if (rst)
			samples <= 0;
		else if (update)
			samples <= samples + 1;
	end
endmodule : scaling_output_sink

// file: verification/tb_top.sv
// self-checking bench for the output scaling datapath
// assumes package, design, checker and output sink compiled first
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		lockin_scale_pkg::conn_t c;
		logic signed [23:0] rx;
		logic signed [39:0] chx;
		logic signed [23:0] ry;
		logic signed [23:0] rr;
		logic signed [39:0] chy;
		logic signed [39:0] chr;
		logic signed [31:0] th;
		lockin_scale_pkg::ind_t ind;
	} note_t;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic meas_valid = 1'b0;
	lockin_scale_pkg::meas_t meas = '0;
	logic signed [15:0] aux3_level = 16'h03E8;
	logic signed [15:0] aux4_level = 16'h03E8;
	logic signed [15:0] aux_three;
	logic signed [15:0] aux_four;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	lockin_scale_pkg::conn_t conn;
	lockin_scale_pkg::conn_t bar;
	lockin_scale_pkg::readout_t readout;
	lockin_scale_pkg::chart_t chart;
	lockin_scale_pkg::ind_t ind;
	logic update;
	int unsigned samples;
	int errors = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h0000003B;
	logic [31:0] rd;
	note_t notes[$];
	always #20 mclk = ~mclk;
	lockin_output_scaling dut (.mclk(mclk), .rst(rst), .meas_valid(meas_valid), .meas(meas),
		.aux_three(aux_three), .aux_four(aux_four), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .conn(conn), .bar(bar),
		.readout(readout), .chart(chart), .ind(ind), .update(update));
	scaling_output_sink sink (.mclk(mclk), .rst(rst), .update(update), .aux3_level(aux3_level),
		.aux4_level(aux4_level), .aux_three(aux_three), .aux_four(aux_four), .samples(samples));
	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xorshift
	function automatic logic signed [31:0] rnd(input logic [31:0] span);
		logic [31:0] u;
		u = xorshift() % span;
		return $signed(u) - $signed(span >> 1);
	endfunction : rnd
	// unclipped code; 128 bits so the products never wrap
	function automatic logic signed [63:0] scale(input logic signed [31:0] v, input logic signed [17:0] off,
		input logic [31:0] sens, input int e, input logic signed [15:0] aux, input int full);
		logic signed [127:0] q;
		q = ((128'(v) * 10000 - 128'(off) * $signed({1'b0, sens})) * e * full * 1000)
			/ ($signed({1'b0, sens}) * 10000 * aux);
		return q[63:0];
	endfunction : scale
	function automatic logic signed [31:0] clip(input logic signed [63:0] q, input int full);
		if (q > full)
			return full;
		if (q < -full)
			return -full;
		return q[31:0];
	endfunction : clip
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] want);
		cmp_count++;
		if (seen !== want) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask : check
	task automatic print_verdict();
		$display("counts: %0d mismatches, %0d comparisons", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic give_up();
		errors++;
		print_verdict();
	endtask : give_up
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		for (n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		if (n == 50)
			give_up();
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wait_updates(input int k);
		int n;
		for (n = 0; n < 400 && k > 0; n++) begin
			@(posedge mclk);
			if (update === 1'b1)
				k--;
		end
		if (k > 0)
			give_up();
	endtask : wait_updates
	// oldest note against each refresh
	always @(posedge mclk) begin
		note_t nt;
		if (update === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check("conn", conn, nt.c);
			check("readout x", readout.x, nt.rx);
			check("chart x", chart.x, nt.chx);
			check("readout y r", {readout.y, readout.r}, {nt.ry, nt.rr});
			check("chart y r", {chart.y, chart.r}, {nt.chy, nt.chr});
			check("readout theta", readout.theta, nt.th);
			check("ind", ind, nt.ind);
		end
	end
	initial begin
		int i;
		int n;
		int ex;
		int er;
		logic [31:0] r;
		logic [7:0] ctrl;
		logic [31:0] sens;
		logic signed [17:0] ox;
		logic signed [17:0] oy;
		logic signed [17:0] orr;
		logic signed [15:0] a3;
		logic signed [15:0] a4;
		logic signed [63:0] qx;
		logic signed [63:0] qy;
		logic signed [63:0] qr;
		lockin_scale_pkg::meas_t m;
		note_t nt;
		int unsigned s0;
		longint lo;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		bus(1'b0, lockin_scale_pkg::ADDR_CTRL, 32'h00000000);
		check("ctrl reset", rd, 32'(lockin_scale_pkg::CTRL_RST));
		bus(1'b0, lockin_scale_pkg::ADDR_SENS, 32'h00000000);
		check("sens reset", rd, lockin_scale_pkg::SENS_RST);
		bus(1'b0, 6'h20, 32'h00000000);
		check("unmapped", rd, 32'h00000000);
		bus(1'b1, lockin_scale_pkg::ADDR_OFF_X, 32'h000186A0);
		bus(1'b0, lockin_scale_pkg::ADDR_OFF_X, 32'h00000000);
		check("offset high", rd, 32'(lockin_scale_pkg::OFF_MAX));
		bus(1'b1, lockin_scale_pkg::ADDR_OFF_X, 32'hFFFE7960);
		bus(1'b1, lockin_scale_pkg::ADDR_SENS, 32'h000186A0);
		bus(1'b0, lockin_scale_pkg::ADDR_OFF_X, 32'h00000000);
		check("offset low", rd, $unsigned(32'(-lockin_scale_pkg::OFF_MAX)));
		avs_byteenable <= 4'h1;
		bus(1'b1, lockin_scale_pkg::ADDR_SENS, 32'hFFFFFFFF);
		avs_byteenable <= 4'hF;
		bus(1'b0, lockin_scale_pkg::ADDR_SENS, 32'h00000000);
		check("byte lanes", rd, 32'h000186FF);
		bus(1'b1, lockin_scale_pkg::ADDR_CTRL, 32'h00000010);
		bus(1'b1, lockin_scale_pkg::ADDR_CTRL, 32'h00000030);
		bus(1'b0, lockin_scale_pkg::ADDR_CTRL, 32'h00000000);
		check("expand code", rd, 32'h00000010);
		s0 = samples;
		repeat (11250) @(posedge mclk);
		lo = longint'(lockin_scale_pkg::RATE_HZ) * 11250 / lockin_scale_pkg::CLK_HZ;
		check("rate", (samples - s0) >= lo && (samples - s0) <= lo + 1, 1'b1);
		for (i = 0; i < 16; i++) begin
			r = xorshift();
			ex = int'(r[1:0]) % 3;
			er = int'(r[3:2]) % 3;
			ctrl = {2'(er), 2'(ex), r[7:4]};
			sens = 32'h0000C350 + (xorshift() % 32'h0000C350);
			ox = r[8] ? 18'(rnd(32'h00004E20)) : 18'h00000;
			oy = r[9] ? 18'(rnd(32'h00004E20)) : 18'h00000;
			orr = r[10] ? 18'(rnd(32'h00004E20)) : 18'h00000;
			a3 = r[11] ? 16'h03E8 : 16'(rnd(32'h000005DC) + 1250);
			a4 = 16'(rnd(32'h000005DC) + 1250);
			m.x = rnd(32'h00061A80);
			m.y = rnd(32'h00061A80);
			m.r = rnd(32'h00061A80) + 200000;
			m.theta = rnd(32'h00057E40);
			bus(1'b1, lockin_scale_pkg::ADDR_CTRL, 32'(ctrl));
			bus(1'b1, lockin_scale_pkg::ADDR_SENS, sens);
			bus(1'b1, lockin_scale_pkg::ADDR_OFF_X, 32'(ox));
			bus(1'b1, lockin_scale_pkg::ADDR_OFF_Y, 32'(oy));
			bus(1'b1, lockin_scale_pkg::ADDR_OFF_R, 32'(orr));
			meas <= m;
			meas_valid <= 1'b1;
			aux3_level <= a3;
			aux4_level <= a4;
			wait_updates(3);
			if (!ctrl[2])
				a3 = 16'h03E8;
			if (!ctrl[3])
				a4 = 16'h03E8;
			qx = scale(m.x, ox, sens, ex == 0 ? 1 : ex == 1 ? 10 : 100, a3, lockin_scale_pkg::FS_CODE);
			qy = scale(m.y, oy, sens, ex == 0 ? 1 : ex == 1 ? 10 : 100, a3, lockin_scale_pkg::FS_CODE);
			qr = scale(m.r, orr, sens, er == 0 ? 1 : er == 1 ? 10 : 100, a4, lockin_scale_pkg::FS_CODE);
			nt.c.x = 16'(clip(qx, lockin_scale_pkg::FS_CODE));
			nt.c.y = 16'(clip(qy, lockin_scale_pkg::FS_CODE));
			nt.c.r = 16'(clip(qr, lockin_scale_pkg::FS_CODE));
			nt.c.theta = 16'((longint'(m.theta) * lockin_scale_pkg::FS_CODE) / lockin_scale_pkg::THETA_HALF);
			nt.c.ch1 = ctrl[0] ? nt.c.r : nt.c.x;
			nt.c.ch2 = ctrl[1] ? nt.c.theta : nt.c.y;
			nt.chx = 40'(scale(m.x, ox, sens, 1, a3, 3000000));
			nt.rx = 24'(clip(nt.chx, 3000000));
			nt.chy = 40'(scale(m.y, oy, sens, 1, a3, 3000000));
			nt.chr = 40'(scale(m.r, orr, sens, 1, a4, 3000000));
			nt.ry = 24'(clip(nt.chy, 3000000));
			nt.rr = 24'(clip(nt.chr, 3000000));
			nt.th = m.theta;
			nt.ind.ratio_lamp = ctrl[2] | ctrl[3];
			nt.ind.offset_ind = {orr != 0, oy != 0, ox != 0};
			nt.ind.ratio_ind = {a4 != 1000, a3 != 1000, a3 != 1000};
			nt.ind.expand_ind = {er != 0, ex != 0, ex != 0};
			nt.ind.overload = {qr > lockin_scale_pkg::FS_CODE || qr < -lockin_scale_pkg::FS_CODE,
				qy > lockin_scale_pkg::FS_CODE || qy < -lockin_scale_pkg::FS_CODE,
				qx > lockin_scale_pkg::FS_CODE || qx < -lockin_scale_pkg::FS_CODE};
			notes.push_back(nt);
			for (n = 0; n < 100 && notes.size() > 0; n++)
				@(posedge mclk);
			if (notes.size() > 0)
				give_up();
			bus(1'b0, lockin_scale_pkg::ADDR_OUT_XY, 32'h00000000);
			check("query x y", rd, {nt.c.y, nt.c.x});
			bus(1'b0, lockin_scale_pkg::ADDR_OUT_RT, 32'h00000000);
			check("query r theta", rd, {nt.c.theta, nt.c.r});
		end
		print_verdict();
	end
endmodule : tb_top
bind lockin_output_scaling lockin_scaling_props #(.RATE_HZ(RATE_HZ)) chk (.mclk(mclk), .rst(rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .conn(conn),
	.bar(bar), .readout(readout), .ind(ind), .update(update));
